// >>> pkg/ust_defines.svh
`ifndef UST_DEFINES_SVH
`define UST_DEFINES_SVH

// Register offsets
`define UST_OFS_INTCTL 8'h0B
`define UST_OFS_IRQFLG 8'h0C
`define UST_OFS_RXSTAT 8'h18
`define UST_OFS_TXBUF 8'h19
`define UST_OFS_IRQEN 8'h8C
`define UST_OFS_TXSTAT 8'h98
`define UST_OFS_BAUD 8'h99

// Field positions
`define UST_BIT_GIE 7
`define UST_BIT_PERIPHERAL_IRQ_ENABLE 6
`define UST_BIT_TXFLAG 4
`define UST_BIT_TX_IRQ_ENABLE 4
`define UST_BIT_SERIAL_PORT_ENABLE 7
`define UST_BIT_SINGLE_RX_ENABLE 5
`define UST_BIT_CONTINUOUS_RX_ENABLE 4
`define UST_BIT_CLOCK_SOURCE_SELECT 7
`define UST_BIT_TX9 6
`define UST_BIT_TRANSMIT_ENABLE 5
`define UST_BIT_SYNC 4
`define UST_BIT_SHIFT_REG_EMPTY 1
`define UST_BIT_NINTH_TX_BIT 0

// Reset values and writable masks
`define UST_RST_INTCTL 8'h00
`define UST_RST_RXSTAT 8'h00
`define UST_RST_TXBUF 8'h00
`define UST_RST_IRQEN 8'h00
`define UST_RST_TXSTAT 8'h02
`define UST_RST_BAUD 8'h00
`define UST_TXSTAT_WMASK 8'hF5

// Counts and fixed values
`define UST_LAST_BIT8 4'h7
`define UST_LAST_BIT9 4'h8
`define UST_IRQ_VECTOR 13'h0004
`define UST_FIFO_DEPTH 32

`endif

// >>> pkg/ust_pkg.sv
package ust_pkg;
   // Shift engine states
   typedef enum logic [0:0] {UST_IDLE, UST_SHIFT} ust_state_t;
   // Buffered word: ninth bit above eight data bits
   typedef logic [8:0] ust_word_t;
endpackage

// >>> hw/ust_fifo.sv
`timescale 1ns/100ps
module ust_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH]; // Word storage
   logic [AW-1:0] wr_ptr_r; // Next slot to fill
   logic [AW-1:0] rd_ptr_r; // Oldest word
   logic [CW-1:0] count_r; // Words held
   logic push;
   logic pop;

   // Flags come straight from the count, so full and empty are exact
   assign in_ready = (count_r != FULL);
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   // Write pointer wraps at depth, which need not be a power of two
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_ptr_r <= '0;
      end else if (push) begin
         wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + AW'(1);
      end
   end

   // Read pointer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_ptr_r <= '0;
      end else if (pop) begin
         rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + AW'(1);
      end
   end

   // Occupancy
   always_ff @(posedge clk) begin
      if (!resetn) begin
         count_r <= '0;
      end else if (push && !pop) begin
         count_r <= count_r + CW'(1);
      end else if (pop && !push) begin
         count_r <= count_r - CW'(1);
      end
   end
endmodule // ust_fifo

// >>> hw/ust_tx.sv
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "ust_defines.svh"

// Functional notes
// - Shift clock only comes from external master
// - Clearing clock source bit selects slave
// - Shifting continues while core is halted
// - Same as master transmit except halt
// - First word loads at once, second waits
// - Reload second word, then set empty flag
// - Empty flag with enable wakes core, vectors
// - Buffer write starts the transfer
// - Empty flag set when enabled, write clears
// - Read-only shift register empty status
module ust_tx #(
   parameter int FIFO_DEPTH = `UST_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_r,
   // Core status and wake
   input wire logic core_halted,
   output logic wake_r,
   output logic irq_req_r,
   output logic [12:0] irq_vector_r,
   // Shared transmit clock pin
   input wire logic tx_clock_pin_i,
   output logic tx_clock_pin_o_r,
   output logic tx_clock_pin_oe_n_r,
   // Serial data pin
   output logic data_pin_o_r,
   output logic data_pin_oe_n_r,
   // Buffer room for the writer
   output logic tx_buffer_ready_r
);
   // Software registers
   logic [7:0] intctl_r; // Global and peripheral enables
   logic [7:0] irqen_r; // Peripheral interrupt enables
   logic [7:0] rxstat_r; // Port enable and receive enables
   logic [7:0] txstat_r; // Mode, framing, enables
   logic [7:0] txbuf_r; // Last byte written to the buffer
   logic [7:0] baud_r; // Unused in slave mode, kept for software
   logic tx_flag_r; // Transmit buffer empty flag

   // Shift engine
   ust_pkg::ust_state_t state_r;
   ust_pkg::ust_word_t tsr_r; // Transmit shift register
   logic [3:0] bit_r; // Index of bit now on the pin
   logic [3:0] last_r; // Index of the frame's last bit

   // Clock pin synchroniser and edge finder
   logic ck_s1_r;
   logic ck_s2_r;
   logic ck_s3_r;
   logic ck_fall;

   // Buffer wiring
   logic wr_tx;
   logic fifo_in_ready;
   logic fifo_valid;
   logic fifo_pop;
   ust_pkg::ust_word_t fifo_data;
   ust_pkg::ust_word_t fifo_wdata;
   logic accepted;

   // Mode decode
   logic transmit_enable;
   logic active;
   logic word_done;

   assign transmit_enable = txstat_r[`UST_BIT_TRANSMIT_ENABLE];
   // Slave transmit needs port, sync, enable and an external clock
   assign active = transmit_enable && rxstat_r[`UST_BIT_SERIAL_PORT_ENABLE] &&
      txstat_r[`UST_BIT_SYNC] && !txstat_r[`UST_BIT_CLOCK_SOURCE_SELECT];
   assign wr_tx = reg_wr && (reg_addr == `UST_OFS_TXBUF);
   assign accepted = wr_tx && fifo_in_ready;
   // Ninth bit is taken at write time, so it must be set before the byte
   assign fifo_wdata = {txstat_r[`UST_BIT_NINTH_TX_BIT], reg_wdata};
   assign ck_fall = ck_s3_r && !ck_s2_r;
   assign word_done = (state_r == ust_pkg::UST_SHIFT) && ck_fall &&
      (bit_r == last_r);
   // Load when the shifter is idle or its last bit just ended
   assign fifo_pop = active && fifo_valid &&
      ((state_r == ust_pkg::UST_IDLE) || word_done);

   // Buffer in front of the shifter
   ust_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(wr_tx),
      .in_ready(fifo_in_ready),
      .in_data(fifo_wdata),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // Two flops on the clock pin before anything looks at it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
      end else begin
         ck_s1_r <= tx_clock_pin_i;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
      end
   end

   // Clock pin is never driven; the master owns it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_clock_pin_o_r <= 1'b0;
         tx_clock_pin_oe_n_r <= 1'b1;
      end else begin
         tx_clock_pin_o_r <= 1'b0;
         tx_clock_pin_oe_n_r <= 1'b1;
      end
   end

   // Enable and mode registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         intctl_r <= `UST_RST_INTCTL;
         irqen_r <= `UST_RST_IRQEN;
         rxstat_r <= `UST_RST_RXSTAT;
         baud_r <= `UST_RST_BAUD;
      end else if (reg_wr) begin
         case (reg_addr)
            `UST_OFS_INTCTL: intctl_r <= reg_wdata;
            `UST_OFS_IRQEN: irqen_r <= reg_wdata;
            `UST_OFS_RXSTAT: rxstat_r <= reg_wdata;
            `UST_OFS_BAUD: baud_r <= reg_wdata;
            default: intctl_r <= intctl_r;
         endcase
      end
   end

   // Transmit status: shifter empty bit is hardware owned
   always_ff @(posedge clk) begin
      if (!resetn) begin
         txstat_r <= `UST_RST_TXSTAT;
      end else begin
         if (reg_wr && (reg_addr == `UST_OFS_TXSTAT)) begin
            txstat_r <= reg_wdata & `UST_TXSTAT_WMASK;
         end else begin
            txstat_r[`UST_BIT_SHIFT_REG_EMPTY] <= 1'b0;
         end
         // Set whenever nothing sits in the shifter
         txstat_r[`UST_BIT_SHIFT_REG_EMPTY] <= (state_r == ust_pkg::UST_IDLE) &&
            !fifo_pop;
      end
   end

   // Copy of the last buffer byte for read-back
   always_ff @(posedge clk) begin
      if (!resetn) begin
         txbuf_r <= `UST_RST_TXBUF;
      end else if (accepted) begin
         txbuf_r <= reg_wdata;
      end
   end

   // Empty flag: a buffer write or clearing transmit enable clears it, an IRQFLG write cannot
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_flag_r <= 1'b0;
      end else begin
         // Rises only once the buffered word has gone into the shifter
         tx_flag_r <= transmit_enable && !accepted && !fifo_valid;
      end
   end

   // Shift engine: advances on the master's falling edge only
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r <= ust_pkg::UST_IDLE;
         tsr_r <= '0;
         bit_r <= 4'h0;
         last_r <= `UST_LAST_BIT8;
      end else if (!active) begin
         // Disabling aborts the word in flight
         state_r <= ust_pkg::UST_IDLE;
         bit_r <= 4'h0;
      end else if (fifo_pop) begin
         // Halt input is ignored: the clock is external
         state_r <= ust_pkg::UST_SHIFT;
         tsr_r <= fifo_data;
         bit_r <= 4'h0;
         last_r <= txstat_r[`UST_BIT_TX9] ? `UST_LAST_BIT9 :
            `UST_LAST_BIT8;
      end else if (word_done) begin
         state_r <= ust_pkg::UST_IDLE;
      end else if ((state_r == ust_pkg::UST_SHIFT) && ck_fall) begin
         tsr_r <= {1'b0, tsr_r[8:1]};
         bit_r <= bit_r + 4'h1;
      end
   end

   // Data pin follows the shifter's low bit while active
   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_pin_o_r <= 1'b1;
         data_pin_oe_n_r <= 1'b1;
      end else begin
         data_pin_oe_n_r <= !active;
         if (fifo_pop) begin
            data_pin_o_r <= fifo_data[0];
         end else if ((state_r == ust_pkg::UST_SHIFT) && ck_fall &&
            !word_done) begin
            data_pin_o_r <= tsr_r[1];
         end
      end
   end

   // Wake and interrupt request from the empty flag
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_r <= 1'b0;
         irq_req_r <= 1'b0;
         irq_vector_r <= 13'h0000;
      end else begin
         wake_r <= tx_flag_r && irqen_r[`UST_BIT_TX_IRQ_ENABLE];
         irq_req_r <= tx_flag_r && irqen_r[`UST_BIT_TX_IRQ_ENABLE] &&
            intctl_r[`UST_BIT_GIE] && intctl_r[`UST_BIT_PERIPHERAL_IRQ_ENABLE];
         irq_vector_r <= `UST_IRQ_VECTOR;
      end
   end

   // Room in the buffer, one cycle late; writes when full are dropped
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_buffer_ready_r <= 1'b0;
      end else begin
         tx_buffer_ready_r <= fifo_in_ready;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `UST_OFS_INTCTL: reg_rdata_r <= intctl_r;
            `UST_OFS_IRQFLG: reg_rdata_r <= {3'h0, tx_flag_r, 4'h0};
            `UST_OFS_RXSTAT: reg_rdata_r <= rxstat_r;
            `UST_OFS_TXBUF: reg_rdata_r <= txbuf_r;
            `UST_OFS_IRQEN: reg_rdata_r <= irqen_r;
            `UST_OFS_TXSTAT: reg_rdata_r <= txstat_r;
            `UST_OFS_BAUD: reg_rdata_r <= baud_r;
            default: reg_rdata_r <= 8'h00;
         endcase
      end else begin
         reg_rdata_r <= 8'h00;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // Two-step reload: shifter busy again, then the flag rises
   sequence s_reload;
      ##1 (state_r == ust_pkg::UST_SHIFT) ##1 tx_flag_r;
   endsequence

   property p_clk_not_driven;
      tx_clock_pin_oe_n_r;
   endproperty
   a_clk_not_driven: assert property (p_clk_not_driven)
      else $error("clock pin driven");

   property p_master_no_shift;
      txstat_r[`UST_BIT_CLOCK_SOURCE_SELECT] |=> (state_r == ust_pkg::UST_IDLE);
   endproperty
   a_master_no_shift: assert property (p_master_no_shift)
      else $error("shifting with internal clock source");

   property p_halt_shift;
      core_halted && (state_r == ust_pkg::UST_SHIFT) && ck_fall &&
      (bit_r != last_r) && active |=> (bit_r == $past(bit_r) + 4'h1);
   endproperty
   a_halt_shift: assert property (p_halt_shift)
      else $error("no shift while halted");

   property p_hold;
      !ck_fall && active && (state_r == ust_pkg::UST_SHIFT) |=>
      $stable(tsr_r) && $stable(bit_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("shifter moved without clock edge");

   property p_first_load;
      active && fifo_valid && (state_r == ust_pkg::UST_IDLE) |=>
      (state_r == ust_pkg::UST_SHIFT) && !tx_flag_r;
   endproperty
   a_first_load: assert property (p_first_load)
      else $error("first word not loaded");

   property p_reload;
      word_done && fifo_valid && active && !wr_tx && !reg_wr |->
      s_reload or (##1 fifo_valid);
   endproperty
   a_reload: assert property (p_reload)
      else $error("second word not reloaded");

   property p_write_clears;
      accepted |=> !tx_flag_r ##1 !txstat_r[`UST_BIT_SHIFT_REG_EMPTY] || !active;
   endproperty
   a_write_clears: assert property (p_write_clears)
      else $error("buffer write did not clear flag");

   property p_wake;
      tx_flag_r && irqen_r[`UST_BIT_TX_IRQ_ENABLE] && intctl_r[`UST_BIT_GIE] &&
      intctl_r[`UST_BIT_PERIPHERAL_IRQ_ENABLE] |=> wake_r && irq_req_r &&
      (irq_vector_r == `UST_IRQ_VECTOR);
   endproperty
   a_wake: assert property (p_wake)
      else $error("no wake or vector on empty flag");

   property p_shift_reg_empty;
      (state_r == ust_pkg::UST_SHIFT) |=> !txstat_r[`UST_BIT_SHIFT_REG_EMPTY];
   endproperty
   a_shift_reg_empty: assert property (p_shift_reg_empty)
      else $error("shifter empty bit set while shifting");
endmodule // ust_tx

// >>> verif/ust_master_model.sv
`timescale 1ns/100ps
// Stand-in for the external synchronous master that owns the shift clock
module ust_master_model (
   // Bench clock, only for the released-line pattern
   clk,
   // Shift clock to the shared pin
   sclk,
   // Serial data from the device
   sdata_o,
   sdata_oe_n
);
   input wire logic clk;
   output logic sclk;
   input wire logic sdata_o;
   input wire logic sdata_oe_n;
   logic flip; // Toggles each cycle
   logic line; // Level the master really sees
   // Clock idles low between frames
   initial begin
      sclk = 1'b0;
      flip = 1'b0;
   end
   // Released line never shows a stale bit
   always @(posedge clk) begin
      flip <= ~flip;
   end
   assign line = sdata_oe_n ? flip : sdata_o;
   // One frame, rising-edge sample, LSB first; slow stretches the low phase
   // Low phase longer than high so the synced device update settles first
   task automatic shift_word(input int n, input int slow,
                             output logic [8:0] w);
      w = 9'h000;
      for (int i = 0; i < n; i++) begin
         #(50 + slow) sclk = 1'b1; // Master makes every edge
         w[i] = line;
         #30 sclk = 1'b0;
      end
   endtask
endmodule // ust_master_model

// >>> verif/ust_tx_test.sv
`timescale 1ns/100ps
`include "ust_defines.svh"
module ust_tx_test;
   logic clk; // Core clock
   logic resetn; // Synchronous reset
   logic [7:0] reg_addr; // Register port
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata_r;
   logic core_halted; // Core sleep state
   logic wake_r;
   logic irq_req_r;
   logic [12:0] irq_vector_r;
   logic sclk; // Master clock drive
   logic pin_clk; // Resolved clock pin
   logic clk_o;
   logic clk_oe_n;
   logic data_o;
   logic data_oe_n;
   logic buf_ready;
   int bad_count;
   int checked;
   logic [8:0] word;
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Pin level from both drivers
   assign pin_clk = clk_oe_n ? sclk : clk_o;
   ust_tx uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_r(reg_rdata_r), .core_halted(core_halted),
      .wake_r(wake_r), .irq_req_r(irq_req_r), .irq_vector_r(irq_vector_r),
      .tx_clock_pin_i(pin_clk), .tx_clock_pin_o_r(clk_o),
      .tx_clock_pin_oe_n_r(clk_oe_n), .data_pin_o_r(data_o),
      .data_pin_oe_n_r(data_oe_n), .tx_buffer_ready_r(buf_ready));
   ust_master_model master (.clk(clk), .sclk(sclk), .sdata_o(data_o),
      .sdata_oe_n(data_oe_n));
   // Verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Single compare for all values
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One write cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // One read cycle; data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_r;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk({5'h00, d}, {5'h00, e});
   endtask
   // Bounded poll for the buffer-empty flag
   task automatic wait_flag();
      logic [7:0] d;
      for (int i = 0; i < 40; i++) begin
         rd(`UST_OFS_IRQFLG, d);
         if (d[`UST_BIT_TXFLAG] === 1'b1) begin
            return;
         end
      end
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, d, 8'h10);
      results();
   endtask
   // Let the reload land, then clock one word out
   task automatic shift_chk(input int n, input logic [8:0] e, input int s);
      repeat (6) @(posedge clk);
      master.shift_word(n, s, word);
      chk({4'h0, word}, {4'h0, e});
   endtask
   task automatic t_reset();
      rd_chk(`UST_OFS_TXSTAT, 8'h02);
      rd_chk(`UST_OFS_IRQFLG, 8'h00);
      rd_chk(`UST_OFS_IRQEN, 8'h00);
      rd_chk(`UST_OFS_INTCTL, 8'h00);
      rd_chk(8'h55, 8'h00);
      wr(`UST_OFS_BAUD, 8'h5A);
      rd_chk(`UST_OFS_BAUD, 8'h5A);
      chk({12'h000, clk_oe_n}, 13'h0001);
      chk({12'h000, data_oe_n}, 13'h0001);
      $display("test reset done");
   endtask
   task automatic t_setup();
      wr(`UST_OFS_IRQEN, 8'h10);
      wr(`UST_OFS_RXSTAT, 8'h80);
      wr(`UST_OFS_TXSTAT, 8'h30);
      rd_chk(`UST_OFS_IRQFLG, 8'h10);
      wr(`UST_OFS_IRQFLG, 8'h00);
      rd_chk(`UST_OFS_IRQFLG, 8'h10);
      rd_chk(`UST_OFS_TXSTAT, 8'h32);
      chk({12'h000, wake_r}, 13'h0001);
      chk({12'h000, irq_req_r}, 13'h0000);
      chk({12'h000, data_oe_n}, 13'h0000);
      wr(`UST_OFS_IRQEN, 8'h00);
      repeat (3) @(posedge clk);
      chk({12'h000, wake_r}, 13'h0000);
      wr(`UST_OFS_IRQEN, 8'h10);
      $display("test setup done");
   endtask
   task automatic t_halt_pair();
      @(posedge clk);
      core_halted <= 1'b1;
      wr(`UST_OFS_TXBUF, 8'hA5);
      wr(`UST_OFS_TXBUF, 8'h3C);
      rd_chk(`UST_OFS_IRQFLG, 8'h00);
      rd_chk(`UST_OFS_TXSTAT, 8'h30);
      chk({12'h000, wake_r}, 13'h0000);
      shift_chk(8, 9'h0A5, 0);
      wait_flag();
      rd_chk(`UST_OFS_TXSTAT, 8'h30);
      chk({12'h000, wake_r}, 13'h0001);
      repeat (20) @(posedge clk);
      chk({12'h000, data_o}, 13'h0000);
      shift_chk(8, 9'h03C, 7);
      repeat (8) @(posedge clk);
      rd_chk(`UST_OFS_TXSTAT, 8'h32);
      $display("test halt pair done");
   endtask
   task automatic t_irq();
      wr(`UST_OFS_INTCTL, 8'hC0);
      repeat (3) @(posedge clk);
      chk({12'h000, irq_req_r}, 13'h0001);
      chk(irq_vector_r, 13'h0004);
      wr(`UST_OFS_TXBUF, 8'h81);
      wr(`UST_OFS_TXBUF, 8'h7E);
      repeat (3) @(posedge clk);
      chk({12'h000, irq_req_r}, 13'h0000);
      shift_chk(8, 9'h081, 0);
      shift_chk(8, 9'h07E, 0);
      wr(`UST_OFS_INTCTL, 8'h00);
      $display("test interrupt done");
   endtask
   task automatic t_nine();
      wr(`UST_OFS_TXSTAT, 8'h10);
      wr(`UST_OFS_TXSTAT, 8'h50);
      wr(`UST_OFS_TXSTAT, 8'h71);
      wr(`UST_OFS_TXBUF, 8'h5A);
      shift_chk(9, 9'h15A, 0);
      wr(`UST_OFS_TXSTAT, 8'h30);
      $display("test nine bit done");
   endtask
   task automatic t_master_sel();
      wr(`UST_OFS_TXSTAT, 8'hB0);
      wr(`UST_OFS_TXBUF, 8'hC3);
      repeat (6) @(posedge clk);
      master.shift_word(8, 0, word);
      rd_chk(`UST_OFS_TXSTAT, 8'hB2);
      chk({12'h000, data_oe_n}, 13'h0001);
      chk({12'h000, clk_oe_n}, 13'h0001);
      wr(`UST_OFS_TXSTAT, 8'h30);
      shift_chk(8, 9'h0C3, 0);
      $display("test clock source done");
   endtask
   task automatic t_fifo();
      for (int i = 0; i < 34; i++) begin
         wr(`UST_OFS_TXBUF, 8'(i));
      end
      repeat (3) @(posedge clk);
      chk({12'h000, buf_ready}, 13'h0000);
      for (int i = 0; i < 33; i++) begin
         shift_chk(8, 9'(i), (i % 3) * 20);
      end
      repeat (8) @(posedge clk);
      chk({12'h000, buf_ready}, 13'h0001);
      rd_chk(`UST_OFS_TXSTAT, 8'h32);
      rd_chk(`UST_OFS_IRQFLG, 8'h10);
      $display("test buffer done");
   endtask
   // Main sequence
   initial begin
      bad_count = 0;
      checked = 0;
      resetn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      core_halted = 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_setup();
      t_halt_pair();
      t_irq();
      t_nine();
      t_master_sel();
      t_fifo();
      results();
   end
endmodule // ust_tx_test
